// [route_sense_pkg.sv]
// Purpose: shared constants and types for input routing and sense control
// Assumes: 8-bit register port, one clock
// Notes: threshold codes map to 75 mV plus 150 mV per step
package route_sense_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int NUM_AIN = 6;

	localparam logic [7:0] OFF_ROUTE = 8'h00;
	localparam logic [7:0] OFF_SENSE_A = 8'h5d;
	localparam logic [7:0] OFF_SENSE_B = 8'h5e;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h60;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h61;
	localparam logic [7:0] OFF_SENSE_RAW = 8'h62;

	localparam int SEL_MSB = 4;
	localparam int PWRDN_BIT = 6;
	localparam int THR_MSB = 4;
	localparam int THR_LSB = 2;

	localparam logic [4:0] SEL_RESET = 5'h00;
	localparam logic PWRDN_RESET = 1'b1;
	localparam logic [2:0] THR_RESET = 3'h3;
	localparam logic [1:0] MASK_RESET = 2'h0;

	localparam int THR_BASE_MV = 75;
	localparam int THR_STEP_MV = 150;

	typedef enum logic [2:0]
	{
		FMT_NONE = 3'h0,
		FMT_CVBS = 3'h1,
		FMT_YC = 3'h3,
		FMT_YPRPB = 3'h2,
		FMT_DIFF = 3'h6
	} video_format_t;

	typedef struct packed
	{
		video_format_t fmt;
		logic [NUM_AIN-1:0] ain_used;
		logic [2:0] luma_ain;
	} route_t;

	typedef struct packed
	{
		logic [4:0] sel;
		logic pwrdn_a;
		logic [2:0] thr_a;
		logic pwrdn_b;
		logic [2:0] thr_b;
		logic [1:0] irq_status;
		logic [1:0] irq_mask;
		logic [1:0] trip_prev;
		logic [DATA_W-1:0] rdata;
		route_t route;
		logic [NUM_AIN-1:0] ain_pwrdn;
		logic irq_n;
	} state_t;

endpackage

// [input_route_and_battery_short_sense_ctrl.sv]
// Purpose: input format routing and short-to-battery sense control
// Assumes: comparator trip inputs are synchronous to clk_sys
// Notes: interrupt pin is active low, level, from a flip-flop
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Five-bit input format selector in bits 4..0 at offset zero.
// - Selector also sets core format: composite, differential, luma/chroma, component.
// - Codes 0..3, 6, 7 route composite from inputs 1..4, 5, 6.
// - Codes 8, 9, 11 route luma/chroma on input pairs 1-2, 3-4, 5-6.
// - Code 12 routes component on inputs 1, 2 and 3.
// - Codes 14, 15, 17 route differential composite on pairs 1-2, 3-4, 5-6.
// - Composite mode powers down every unused analog input.
// - Sense pin above its threshold registers a short-to-battery event.
// - Event raises the active-low interrupt request pin.
// - Readable status shows which sense pin tripped.
// - Diagnostics are disabled after reset until software enables them.
// - Offset 0x5d bit 6 powers down sense pin A comparator; resets to 1.
// - Offset 0x5d bits 4..2 pick pin A threshold; reset code 3.
// - Offset 0x5e bit 6 powers down sense pin B comparator; resets to 1.
// - Offset 0x5e bits 4..2 pick pin B threshold; reset code 3.
module input_route_and_battery_short_sense_ctrl
	import route_sense_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	// Comparator outputs, high while a pin is above its threshold
	input wire logic [1:0] sense_trip,
	// Analog front end control
	output logic [NUM_AIN-1:0] ain_pwrdn,
	output logic [2:0] video_format,
	output logic [2:0] luma_ain,
	output logic sense_a_comparator_powerdown,
	output logic [2:0] sense_a_threshold,
	output logic sense_b_comparator_powerdown,
	output logic [2:0] sense_b_threshold,
	// Interrupt
	output logic interrupt_request_pin_n
);

	state_t st_r;
	state_t st_nxt;

	// Decodes a selector code into format and used inputs
	function automatic route_t decode_route(input logic [4:0] sel);
		route_t r;
		r.fmt = FMT_NONE;
		r.ain_used = 6'h00;
		r.luma_ain = 3'h0;
		unique case (sel)
			5'h00, 5'h01, 5'h02, 5'h03:
			begin
				r.fmt = FMT_CVBS;
				r.ain_used = 6'h01 << sel[1:0];
				r.luma_ain = 3'(sel[1:0]) + 3'h1;
			end
			5'h06, 5'h07:
			begin
				r.fmt = FMT_CVBS;
				r.ain_used = (sel[0]) ? 6'h20 : 6'h10;
				r.luma_ain = (sel[0]) ? 3'h6 : 3'h5;
			end
			5'h08, 5'h09:
			begin
				r.fmt = FMT_YC;
				r.ain_used = (sel[0]) ? 6'h0c : 6'h03;
				r.luma_ain = (sel[0]) ? 3'h3 : 3'h1;
			end
			5'h0b:
			begin
				// Code 11 skips a step: luma on input 5, chroma on 6
				r.fmt = FMT_YC;
				r.ain_used = 6'h30;
				r.luma_ain = 3'h5;
			end
			5'h0c:
			begin
				r.fmt = FMT_YPRPB;
				r.ain_used = 6'h07;
				r.luma_ain = 3'h1;
			end
			5'h0e, 5'h0f:
			begin
				r.fmt = FMT_DIFF;
				r.ain_used = (sel[0]) ? 6'h0c : 6'h03;
				r.luma_ain = (sel[0]) ? 3'h3 : 3'h1;
			end
			5'h11:
			begin
				r.fmt = FMT_DIFF;
				r.ain_used = 6'h30;
				r.luma_ain = 3'h5;
			end
			default:
			begin
				// Reserved codes leave every input unrouted
				r.fmt = FMT_NONE;
			end
		endcase
		return r;
	endfunction

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] off);
		return a == off;
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		logic [1:0] trip_live;
		logic [1:0] rise;
		logic [1:0] clr;
		trip_live = 2'h0;
		rise = 2'h0;
		clr = 2'h0;
		st_nxt = st_r;

		// Register writes
		if (reg_wr)
		begin
			if (hit(reg_addr, OFF_ROUTE))
				st_nxt.sel = reg_wdata[SEL_MSB:0];
			if (hit(reg_addr, OFF_SENSE_A))
			begin
				st_nxt.pwrdn_a = reg_wdata[PWRDN_BIT];
				st_nxt.thr_a = reg_wdata[THR_MSB:THR_LSB];
			end
			if (hit(reg_addr, OFF_SENSE_B))
			begin
				st_nxt.pwrdn_b = reg_wdata[PWRDN_BIT];
				st_nxt.thr_b = reg_wdata[THR_MSB:THR_LSB];
			end
			if (hit(reg_addr, OFF_IRQ_MASK))
				st_nxt.irq_mask = reg_wdata[1:0];
			if (hit(reg_addr, OFF_IRQ_STATUS))
				clr = reg_wdata[1:0];
		end

		// Powered-down comparators report nothing
		trip_live[0] = sense_trip[0] & ~st_r.pwrdn_a;
		trip_live[1] = sense_trip[1] & ~st_r.pwrdn_b;
		rise = trip_live & ~st_r.trip_prev;
		st_nxt.trip_prev = trip_live;
		// Set wins over a same-cycle clear
		st_nxt.irq_status = (st_r.irq_status & ~clr) | rise;

		// Register reads, data valid the next cycle
		st_nxt.rdata = '0;
		if (reg_rd)
		begin
			if (hit(reg_addr, OFF_ROUTE))
				st_nxt.rdata = DATA_W'(st_r.sel);
			else if (hit(reg_addr, OFF_SENSE_A))
			begin
				st_nxt.rdata[PWRDN_BIT] = st_r.pwrdn_a;
				st_nxt.rdata[THR_MSB:THR_LSB] = st_r.thr_a;
			end
			else if (hit(reg_addr, OFF_SENSE_B))
			begin
				st_nxt.rdata[PWRDN_BIT] = st_r.pwrdn_b;
				st_nxt.rdata[THR_MSB:THR_LSB] = st_r.thr_b;
			end
			else if (hit(reg_addr, OFF_IRQ_STATUS))
				st_nxt.rdata = DATA_W'(st_r.irq_status);
			else if (hit(reg_addr, OFF_IRQ_MASK))
				st_nxt.rdata = DATA_W'(st_r.irq_mask);
			else if (hit(reg_addr, OFF_SENSE_RAW))
				st_nxt.rdata = DATA_W'(st_r.trip_prev);
		end

		// Routing and power-down of unused inputs
		st_nxt.route = decode_route(st_nxt.sel);
		st_nxt.ain_pwrdn = ~st_nxt.route.ain_used;

		// Active-low level interrupt
		st_nxt.irq_n = ~|(st_nxt.irq_status & st_nxt.irq_mask);
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			st_r <= '0;
			st_r.sel <= SEL_RESET;
			st_r.pwrdn_a <= PWRDN_RESET;
			st_r.thr_a <= THR_RESET;
			st_r.pwrdn_b <= PWRDN_RESET;
			st_r.thr_b <= THR_RESET;
			st_r.irq_mask <= MASK_RESET;
			st_r.route <= '{fmt: FMT_CVBS, ain_used: 6'h01, luma_ain: 3'h1};
			st_r.ain_pwrdn <= 6'h3e;
			st_r.irq_n <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	assign reg_rdata = st_r.rdata;
	assign ain_pwrdn = st_r.ain_pwrdn;
	assign video_format = st_r.route.fmt;
	assign luma_ain = st_r.route.luma_ain;
	assign sense_a_comparator_powerdown = st_r.pwrdn_a;
	assign sense_a_threshold = st_r.thr_a;
	assign sense_b_comparator_powerdown = st_r.pwrdn_b;
	assign sense_b_threshold = st_r.thr_b;
	assign interrupt_request_pin_n = st_r.irq_n;

endmodule

`default_nettype wire

// [route_sense_chk_assertions.sv]
// Purpose: port checks for input routing and sense control
// Assumes: bound to the top module, one clock domain
// Notes: trip to pin takes one cycle
`timescale 1ns/1ns
`default_nettype none
module route_sense_chk
	import route_sense_pkg::*;
(
	// Clock, reset and register port
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	// Sense and control outputs
	input wire logic [1:0] sense_trip,
	input wire logic [NUM_AIN-1:0] ain_pwrdn,
	input wire logic [2:0] video_format,
	input wire logic [2:0] luma_ain,
	input wire logic sense_a_comparator_powerdown,
	input wire logic [2:0] sense_a_threshold,
	input wire logic sense_b_comparator_powerdown,
	input wire logic [2:0] sense_b_threshold,
	input wire logic interrupt_request_pin_n
);
default clocking @(posedge clk_sys); endclocking
default disable iff (!rst_n);
wire logic w0 = reg_wr && reg_addr == OFF_ROUTE;
wire logic wa = reg_wr && reg_addr == OFF_SENSE_A;
wire logic wb = reg_wr && reg_addr == OFF_SENSE_B;
wire logic wm = reg_wr && reg_addr == OFF_IRQ_MASK;
a_cvbs_route: assert property (w0 && reg_wdata[7:2] == 6'h00 |=>
	video_format == 3'h1 && luma_ain == $past(reg_wdata[2:0]) + 3'h1)
	else $error("composite route wrong");
a_cvbs_pwrdn: assert property (video_format == 3'h1
	|-> ain_pwrdn == ~(6'h01 << (luma_ain - 3'h1)))
	else $error("unused inputs not powered down");
a_yc_route: assert property (w0 && reg_wdata == 8'h09 |=>
	video_format == 3'h3 && luma_ain == 3'h3 && ain_pwrdn == 6'h33)
	else $error("luma chroma route wrong");
a_diff_route: assert property (w0 && reg_wdata == 8'h11 |=>
	video_format == 3'h6 && luma_ain == 3'h5 && ain_pwrdn == 6'h0f)
	else $error("differential route wrong");
a_sense_a_cfg: assert property (wa |=>
	sense_a_comparator_powerdown == $past(reg_wdata[6])
	&& sense_a_threshold == $past(reg_wdata[4:2]))
	else $error("sense a config wrong");
a_sense_b_cfg: assert property (wb |=>
	sense_b_comparator_powerdown == $past(reg_wdata[6])
	&& sense_b_threshold == $past(reg_wdata[4:2]))
	else $error("sense b config wrong");
a_irq_cause: assert property ($fell(interrupt_request_pin_n) |->
	$past(sense_trip) != 2'h0 || $past(sense_trip, 2) != 2'h0
	|| $past(wm))
	else $error("interrupt without trip");
a_irq_clear: assert property (reg_wr && reg_addr == OFF_IRQ_STATUS
	&& reg_wdata[1:0] == 2'h3 && $past(sense_trip) == sense_trip
	&& $past(sense_trip, 2) == sense_trip |=> interrupt_request_pin_n)
	else $error("interrupt not cleared");
a_sel_bits: assert property (reg_rd && reg_addr == OFF_ROUTE |=>
	reg_rdata[7:5] == 3'h0) else $error("selector upper bits set");
cover property (w0);
cover property ($fell(interrupt_request_pin_n));
cover property (reg_wr && reg_addr == OFF_IRQ_STATUS);
endmodule
`default_nettype wire

// [test_input_route_and_battery_short_sense_ctrl.sv]
// Purpose: register level test of routing and sense control
// Assumes: comparator trips driven directly by the bench
// Notes: reserved selector codes route nothing
`timescale 1ns/1ns
`default_nettype none
module test_input_route_and_battery_short_sense_ctrl
	import route_sense_pkg::*;
();
logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
logic [1:0] sense_trip = 2'h0;
logic [5:0] ain_pwrdn;
logic [2:0] video_format, luma_ain, sense_a_threshold, sense_b_threshold;
logic sense_a_comparator_powerdown, sense_b_comparator_powerdown;
logic interrupt_request_pin_n;
int errors = 0, tests_run = 0;
wire logic [11:0] rt_now = {video_format, luma_ain, ain_pwrdn};
wire logic [11:0] sns = {4'h0, sense_a_comparator_powerdown,
	sense_a_threshold, sense_b_comparator_powerdown, sense_b_threshold};
wire logic [11:0] pin = {11'h0, interrupt_request_pin_n};
// Format, first input and powerdown per selector code
localparam logic [11:0] RT [18] = '{12'h27e, 12'h2bd, 12'h2fb, 12'h337,
	12'h03f, 12'h03f, 12'h36f, 12'h39f, 12'h67c, 12'h6f3, 12'h03f,
	12'h74f, 12'h478, 12'h03f, 12'hc7c, 12'hcf3, 12'h03f, 12'hd4f};
input_route_and_battery_short_sense_ctrl u_input_route_and_battery_short_sense_ctrl (.*);
task chk(input string n, input logic [11:0] e, input logic [11:0] g);
	tests_run++;
	if (g !== e)
	begin
		errors++;
		$display("MISMATCH %s exp %h got %h", n, e, g);
	end
endtask
task step(input int n);
	repeat (n) @(posedge clk_sys);
	#1;
endtask
task wr(input logic [7:0] a, input logic [7:0] d);
	@(posedge clk_sys);
	reg_addr <= a;
	reg_wdata <= d;
	reg_wr <= 1'b1;
	@(posedge clk_sys);
	reg_wr <= 1'b0;
endtask
task rd(input logic [7:0] a, input logic [7:0] e);
	@(posedge clk_sys);
	reg_addr <= a;
	reg_rd <= 1'b1;
	@(posedge clk_sys);
	reg_rd <= 1'b0;
	#1;
	chk($sformatf("reg %h", a), {4'h0, e}, {4'h0, reg_rdata});
endtask
task trip(input logic [1:0] v);
	@(posedge clk_sys);
	sense_trip <= v;
	step(4);
endtask
task summarize;
	if (errors == 0 && tests_run > 0)
		$display("No errors found");
	else
		$display("Errors were found");
	$finish;
endtask
initial forever #10 clk_sys = ~clk_sys;
initial
begin
	repeat (5) @(posedge clk_sys);
	rst_n <= 1'b1;
	step(1);
	chk("route", 12'h27e, rt_now);
	chk("sense", 12'h0bb, sns);
	rd(OFF_SENSE_A, 8'h4c);
	rd(OFF_SENSE_B, 8'h4c);
	rd(OFF_ROUTE, 8'h00);
	rd(OFF_IRQ_MASK, 8'h00);
	rd(8'h10, 8'h00);
	wr(OFF_IRQ_MASK, 8'h03);
	trip(2'h3);
	rd(OFF_IRQ_STATUS, 8'h00);
	chk("pin", 12'h1, pin);
	trip(2'h0);
	wr(OFF_SENSE_A, 8'hff);
	rd(OFF_SENSE_A, 8'h5c);
	wr(OFF_SENSE_A, 8'h00);
	wr(OFF_SENSE_B, 8'h1c);
	step(1);
	chk("sense", 12'h007, sns);
	trip(2'h1);
	rd(OFF_IRQ_STATUS, 8'h01);
	chk("pin", 12'h0, pin);
	trip(2'h2);
	rd(OFF_IRQ_STATUS, 8'h03);
	rd(OFF_SENSE_RAW, 8'h02);
	wr(OFF_IRQ_STATUS, 8'h01);
	rd(OFF_IRQ_STATUS, 8'h02);
	wr(OFF_IRQ_MASK, 8'h01);
	step(2);
	chk("pin", 12'h1, pin);
	wr(OFF_IRQ_MASK, 8'h03);
	step(2);
	chk("pin", 12'h0, pin);
	wr(OFF_IRQ_STATUS, 8'hff);
	step(2);
	chk("pin", 12'h1, pin);
	rd(OFF_IRQ_STATUS, 8'h00);
	trip(2'h0);
	for (int i = 0; i < 18; i++)
	begin
		wr(OFF_ROUTE, 8'(i));
		step(2);
		chk("route", RT[i], rt_now);
	end
	wr(OFF_ROUTE, 8'hff);
	rd(OFF_ROUTE, 8'h1f);
	chk("route", 12'h03f, rt_now);
	summarize;
end
endmodule
bind input_route_and_battery_short_sense_ctrl route_sense_chk u_route_sense_chk (.*);
`default_nettype wire
